// [sfbs_fifo.sv]
`timescale 1ns/1ps
module sfbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  sfbs_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
    logic [WIDTH-1:0] out;
    logic out_v;
  } sfbs_fifo_type;
  sfbs_fifo_type s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic [AW:0] used;

  // Full counts the output register too, so DEPTH words in total
  assign used = s_q.wr - s_q.rd;
  assign full = (used == (AW+1)'(DEPTH)) || ((used == (AW+1)'(DEPTH - 1)) && s_q.out_v);
  assign empty = (s_q.wr == s_q.rd);
  assign push = port.in_valid && !full;
  assign port.in_ready = !full;
  assign port.out_data = s_q.out;
  assign port.out_valid = s_q.out_v;

  // Registered read data stage
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (!empty && (!s_q.out_v || port.out_ready)) begin
      s_d.out = mem_q[s_q.rd[AW-1:0]];
      s_d.out_v = 1'b1;
      s_d.rd = s_q.rd + 1'b1;
    end else if (port.out_ready) begin
      s_d.out_v = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
    if (push) begin
      mem_q[s_q.wr[AW-1:0]] <= port.in_data;
    end
  end
endmodule

// [sfbs_fifo_if.sv]
`timescale 1ns/1ps
interface sfbs_fifo_if;
  logic [7:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [7:0] out_data;
  logic out_valid;
  logic out_ready;
  modport fifo (input in_data, input in_valid, output in_ready,
    output out_data, output out_valid, input out_ready);
  modport user (output in_data, output in_valid, input in_ready,
    input out_data, input out_valid, output out_ready);
endinterface

// [sfbs_flash_model.sv]
`timescale 1ns/1ps
module sfbs_flash_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso
);
  // Protection set at power-up; hold and protect pins assumed tied high
  logic [7:0] sr, tx, op, st, ops[$], dat[$];
  logic [23:0] addr;
  logic write_latch_bit;
  int nb, lag, busy, bits[$];
  initial begin
    miso = 1'b0;
    st = 8'hFC;
    write_latch_bit = 1'b0;
    lag = 0;
    busy = 0;
    nb = 0;
  end
  ////////////////////////////////////////////////////////////////
  // Mode 0 byte capture, one status byte only
  always @(posedge sck) if (!cs_n) begin
    sr = {sr[6:0], mosi};
    nb++;
    if (nb % 8 == 0) begin
      if (nb == 8) op = sr;
      else if (op != 8'h05 && (op != 8'h0B || nb <= 40)) dat.push_back(sr);
      if (op == 8'h0B && nb >= 16 && nb <= 32) addr = {addr[15:0], sr};
      // Busy in bit 0, latch in bit 1
      tx = (op == 8'h05) ? {st[7:2], write_latch_bit && lag == 0, busy != 0} :
        (op == 8'h0B && nb >= 40) ? addr[7:0] + 8'hA0 + 8'((nb - 40) / 8) : 8'h00;
    end
  end
  // Answer shifts out on the falling edge
  always @(negedge sck) if (!cs_n) begin
    miso = tx[7];
    tx = {tx[6:0], 1'b0};
  end
  always @(negedge cs_n) begin
    nb = 0;
    tx = 8'h00;
  end
  // Frame end: latch is slow to show, cleared by writes
  always @(posedge cs_n) begin
    miso = ~miso;
    if (nb > 0) begin
      ops.push_back(op);
      bits.push_back(nb);
      case (op)
        8'h06: begin write_latch_bit = 1'b1; lag = 2; end
        8'h05: begin if (lag > 0) lag--; if (busy > 0) busy--; end
        8'h01: begin if (write_latch_bit) st = sr; write_latch_bit = 1'b0; end
        8'h02, 8'h20, 8'hC7: begin if (write_latch_bit) busy = 2; write_latch_bit = 1'b0; end
        default: ;
      endcase
    end
  end
endmodule

// [sfbs_pkg.sv]
package sfbs_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  // Status byte fields and values, fast-read dummy byte
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam logic [7:0] STATUS_CLEAR = 8'h00;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  // System, link and serial clock rates
  localparam int SYS_CLK_KHZ = 40000;
  localparam int SLOW_SCK_KHZ = 1420;
  localparam int FAST_SCK_KHZ = 30000;
  localparam int LINK_CLK_KHZ = 166667;
  // Half periods of the serial clock in link-clock cycles, at least one
  localparam int SLOW_HALF_RAW = LINK_CLK_KHZ / (2 * SLOW_SCK_KHZ);
  localparam int FAST_HALF_RAW = LINK_CLK_KHZ / (2 * FAST_SCK_KHZ);
  localparam logic [7:0] SLOW_HALF = 8'(SLOW_HALF_RAW < 1 ? 1 : SLOW_HALF_RAW);
  localparam logic [7:0] FAST_HALF = 8'(FAST_HALF_RAW < 1 ? 1 : FAST_HALF_RAW);
  // Chip-select high time between commands, in link cycles
  localparam int CS_HIGH_NS = 200;
  localparam logic [7:0] CS_HIGH_CYC = 8'((CS_HIGH_NS * LINK_CLK_KHZ + 999999) / 1000000);
  // Page geometry and FIFO depth
  localparam int PAGE_BYTES = 256;
  localparam int FIFO_DEPTH = 8;
  localparam logic [8:0] PAGE_LEN = 9'h100;
  // Request kinds
  typedef enum logic [2:0] {
    SFBS_REQ_NONE = 3'b000,
    SFBS_REQ_PROGRAM = 3'b001,
    SFBS_REQ_SECTOR = 3'b010,
    SFBS_REQ_CHIP = 3'b011,
    SFBS_REQ_READ = 3'b100
  } sfbs_req_type;
endpackage

// [sfbs_sequencer.sv]
`timescale 1ns/1ps
// Behaviour
// - Mode 0 clocking, single data line
// - Status bit 0 means flash busy
// - Status bit 1 is write latch, polled
// - One status byte per status command
// - Always remove protection during boot
// - Boot: write enable then poll latch
// - Boot: write zero status byte
// - Write enable and poll before program/erase
// - Fixed protocol and rate, no detection
// - Fixed single-byte opcodes, dummy for fast read
// - Start slow serial clock, later fast
// - Boot from chip select zero
// - Hold and write-protect not driven
module sfbs_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic [2:0] req_kind,
  input wire logic [23:0] req_addr,
  input wire logic [8:0] req_len,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic boot_done,
  output logic seq_busy,
  output logic [7:0] last_status,
  output logic boot_chip_select,
  output logic chip_select_1,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_BOOT_WE = 4'h1, ST_POLL = 4'h2, ST_BOOT_WS = 4'h3,
    ST_WAIT = 4'h4, ST_OP = 4'h5, ST_READY = 4'h6, ST_BUSY_POLL = 4'h7
  } sfbs_state_type;

  typedef struct packed {
    sfbs_state_type st;
    sfbs_state_type after;
    logic boot;
    logic fast;
    logic go_tgl;
    logic done_sync1, done_sync2, done_sync3;
    logic take_sync1, take_sync2, take_sync3;
    logic rd_sync1, rd_sync2, rd_sync3;
    logic [2:0] kind;
    logic [23:0] addr;
    logic [8:0] len;
    logic [7:0] status;
    logic req_ready;
    logic seq_busy;
  } sfbs_sys_type;

  typedef struct packed {
    logic go1, go2, go3, go_seen;
    logic done_tgl;
    logic take_tgl;
    logic rd_tgl;
    logic [7:0] rd_hold;
    logic active;
    logic sck;
    logic cs_n;
    logic mosi;
    logic [7:0] half;
    logic [7:0] gap;
    logic [7:0] sh;
    logic [2:0] bit_n;
    logic [3:0] hdr_n;
    logic [8:0] data_n;
    logic [7:0] rx;
    logic rx_v;
    logic phase;
  } sfbs_link_type;

  sfbs_sys_type s_q, s_d;
  sfbs_link_type l_q, l_d;
  sfbs_fifo_if wq ();
  sfbs_fifo_if rq ();
  logic [7:0] op_code;
  logic [3:0] hdr_len;
  logic data_in;
  logic done_evt;
  logic take_evt;
  logic rd_evt;
  logic [2:0] lrst_q;
  logic [3:0] hdr_pos;
  logic [7:0] miso_s1_q, miso_s2_q, miso_s3_q;
  logic [7:0] hdr_byte;

  ////////////////////////////////////////////////////////////////
  // Write and read FIFOs, system side stalls on full
  sfbs_fifo #(.WIDTH(8), .DEPTH(sfbs_pkg::FIFO_DEPTH)) u_wfifo (.clk(clk), .rst(rst), .port(wq));
  sfbs_fifo #(.WIDTH(8), .DEPTH(sfbs_pkg::FIFO_DEPTH)) u_rfifo (.clk(clk), .rst(rst), .port(rq));
  assign wq.in_data = wr_data;
  assign wq.in_valid = wr_valid;
  assign wr_ready = wq.in_ready;
  assign rd_data = rq.out_data;
  assign rd_valid = rq.out_valid;
  assign rq.out_ready = 1'b1;
  assign req_ready = s_q.req_ready;
  assign boot_done = !s_q.boot;
  assign seq_busy = s_q.seq_busy;
  assign last_status = s_q.status;
  assign chip_select_1 = 1'b1;

  // Opcode for the command about to go out
  always_comb begin
    op_code = sfbs_pkg::OP_READ_STATUS;
    hdr_len = 4'h1;
    data_in = 1'b0;
    case (s_q.st)
      ST_BOOT_WE: op_code = sfbs_pkg::OP_WRITE_ENABLE;
      ST_BOOT_WS: begin
        op_code = sfbs_pkg::OP_WRITE_STATUS;
        hdr_len = 4'h2;
      end
      ST_OP: begin
        case (s_q.kind)
          3'(sfbs_pkg::SFBS_REQ_PROGRAM): begin
            op_code = sfbs_pkg::OP_PAGE_PROGRAM;
            hdr_len = 4'h4;
          end
          3'(sfbs_pkg::SFBS_REQ_SECTOR): begin
            op_code = sfbs_pkg::OP_SECTOR_ERASE;
            hdr_len = 4'h4;
          end
          3'(sfbs_pkg::SFBS_REQ_CHIP): op_code = sfbs_pkg::OP_CHIP_ERASE;
          default: begin
            op_code = sfbs_pkg::OP_FAST_READ;
            hdr_len = 4'h5;
            data_in = 1'b1;
          end
        endcase
      end
      ST_WAIT: op_code = sfbs_pkg::OP_WRITE_ENABLE;
      default: op_code = sfbs_pkg::OP_READ_STATUS;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // System-side sequencer
  assign done_evt = s_q.done_sync2 ^ s_q.done_sync3;
  assign take_evt = s_q.take_sync2 ^ s_q.take_sync3;
  assign rd_evt = s_q.rd_sync2 ^ s_q.rd_sync3;
  always_comb begin
    s_d = s_q;
    s_d.done_sync1 = l_q.done_tgl;
    s_d.done_sync2 = s_q.done_sync1;
    s_d.done_sync3 = s_q.done_sync2;
    s_d.take_sync1 = l_q.take_tgl;
    s_d.take_sync2 = s_q.take_sync1;
    s_d.take_sync3 = s_q.take_sync2;
    s_d.rd_sync1 = l_q.rd_tgl;
    s_d.rd_sync2 = s_q.rd_sync1;
    s_d.rd_sync3 = s_q.rd_sync2;
    s_d.req_ready = 1'b0;
    // Only status polls update the reported status byte
    if (done_evt && (s_q.st == ST_POLL || s_q.st == ST_BUSY_POLL)) begin
      s_d.status = l_q.rx;
    end
    case (s_q.st)
      ST_IDLE: begin
        s_d.st = ST_BOOT_WE;
        s_d.after = ST_BOOT_WS;
        s_d.go_tgl = !s_q.go_tgl;
        s_d.seq_busy = 1'b1;
      end
      ST_BOOT_WE, ST_WAIT: begin
        if (done_evt) begin
          s_d.st = ST_POLL;
          s_d.go_tgl = !s_q.go_tgl;
        end
      end
      ST_POLL: begin
        if (done_evt) begin
          if (l_q.rx[sfbs_pkg::LATCH_BIT]) begin
            s_d.st = s_q.after;
          end
          s_d.go_tgl = !s_q.go_tgl;
        end
      end
      ST_BOOT_WS: begin
        // Zero all status bits, then go fast
        if (done_evt) begin
          s_d.boot = 1'b0;
          s_d.fast = 1'b1;
          s_d.st = ST_READY;
          s_d.seq_busy = 1'b0;
        end
      end
      ST_READY: begin
        s_d.req_ready = 1'b1;
        if (req_valid && s_q.req_ready) begin
          s_d.req_ready = 1'b0;
          s_d.kind = req_kind;
          s_d.addr = req_addr;
          // Program length clipped to page end
          s_d.len = (req_len > sfbs_pkg::PAGE_LEN - {1'b0, req_addr[7:0]}) ?
            sfbs_pkg::PAGE_LEN - {1'b0, req_addr[7:0]} : req_len;
          s_d.seq_busy = 1'b1;
          s_d.go_tgl = !s_q.go_tgl;
          if (req_kind == 3'(sfbs_pkg::SFBS_REQ_READ)) begin
            s_d.len = req_len;
            s_d.st = ST_OP;
          end else begin
            // Write enable precedes program or erase
            s_d.st = ST_WAIT;
            s_d.after = ST_OP;
          end
        end
      end
      ST_OP: begin
        if (done_evt) begin
          // Flash drops latch itself; wait busy
          s_d.st = (s_q.kind == 3'(sfbs_pkg::SFBS_REQ_READ)) ? ST_READY : ST_BUSY_POLL;
          s_d.seq_busy = (s_q.kind != 3'(sfbs_pkg::SFBS_REQ_READ));
          if (s_q.kind != 3'(sfbs_pkg::SFBS_REQ_READ)) begin
            s_d.go_tgl = !s_q.go_tgl;
          end
        end
      end
      ST_BUSY_POLL: begin
        // Busy bit held until operation ends
        if (done_evt) begin
          if (!l_q.rx[sfbs_pkg::BUSY_BIT]) begin
            s_d.st = ST_READY;
            s_d.seq_busy = 1'b0;
          end else begin
            s_d.go_tgl = !s_q.go_tgl;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.boot <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Link side: one command per go toggle
  // Toggle handshakes: held bytes stay put long after each toggle is seen
  assign wq.out_ready = take_evt;
  assign rq.in_data = l_q.rd_hold;
  assign rq.in_valid = rd_evt;
  assign hdr_pos = l_q.hdr_n + (4'h5 - hdr_len);

  // Header byte by position, status write sends zero
  always_comb begin
    case (hdr_pos)
      4'h4: hdr_byte = (hdr_len == 4'h2) ? sfbs_pkg::STATUS_CLEAR : s_q.addr[23:16];
      4'h3: hdr_byte = s_q.addr[15:8];
      4'h2: hdr_byte = s_q.addr[7:0];
      4'h1: hdr_byte = sfbs_pkg::DUMMY_BYTE;
      default: hdr_byte = wq.out_data;
    endcase
  end

  always_comb begin
    l_d = l_q;
    l_d.go1 = s_q.go_tgl;
    l_d.go2 = l_q.go1;
    l_d.go3 = l_q.go2;
    l_d.rx_v = 1'b0;
    if (!l_q.active) begin
      l_d.cs_n = 1'b1;
      l_d.sck = 1'b0;
      if (l_q.gap != 8'h0) begin
        l_d.gap = l_q.gap - 8'h01;
      end else if (l_q.go2 != l_q.go_seen && l_q.go2 == l_q.go3) begin
        // New transaction after chip select gap
        l_d.go_seen = l_q.go2;
        l_d.active = 1'b1;
        l_d.cs_n = 1'b0;
        l_d.sh = op_code;
        l_d.mosi = op_code[7];
        l_d.bit_n = 3'h7;
        l_d.hdr_n = hdr_len - 4'h1;
        l_d.data_n = (hdr_len == 4'h1 && op_code == sfbs_pkg::OP_READ_STATUS) ? 9'h1 :
          ((hdr_len >= 4'h4) ? s_q.len : 9'h0);
        l_d.half = s_q.fast ? sfbs_pkg::FAST_HALF : sfbs_pkg::SLOW_HALF;
        l_d.phase = 1'b0;
      end
    end else if (l_q.half != 8'h01) begin
      l_d.half = l_q.half - 8'h01;
    end else begin
      // Rate fixed per phase, never adapted
      l_d.half = s_q.fast ? sfbs_pkg::FAST_HALF : sfbs_pkg::SLOW_HALF;
      l_d.sck = !l_q.sck;
      if (l_q.sck) begin
        // Mode 0: shift on falling edge; bit from the previous fall
        // taken here because the input stages outlast a fast low phase
        l_d.rx = {l_q.rx[6:0], miso_s3_q[0]};
        if (l_q.bit_n != 3'h0) begin
          l_d.bit_n = l_q.bit_n - 3'h1;
          l_d.sh = {l_q.sh[6:0], 1'b0};
          l_d.mosi = l_q.sh[6];
        end else if (l_q.hdr_n != 4'h0 || l_q.data_n != 9'h0) begin
          l_d.bit_n = 3'h7;
          if (l_q.phase) begin
            // Fast read data byte complete, one data byte out
            l_d.rx_v = data_in;
          end
          if (l_q.hdr_n != 4'h0) begin
            l_d.hdr_n = l_q.hdr_n - 4'h1;
            l_d.sh = hdr_byte;
            l_d.mosi = hdr_byte[7];
          end else begin
            l_d.phase = 1'b1;
            l_d.data_n = l_q.data_n - 9'h1;
            if (s_q.st == ST_OP && s_q.kind == 3'(sfbs_pkg::SFBS_REQ_PROGRAM)) begin
              l_d.sh = wq.out_data;
              l_d.mosi = wq.out_data[7];
              l_d.take_tgl = !l_q.take_tgl;
            end else begin
              l_d.sh = 8'h00;
              l_d.mosi = 1'b0;
            end
          end
        end else begin
          l_d.rx_v = data_in;
          l_d.active = 1'b0;
          l_d.cs_n = 1'b1;
          l_d.sck = 1'b0;
          l_d.gap = sfbs_pkg::CS_HIGH_CYC;
          l_d.done_tgl = !l_q.done_tgl;
        end
      end
    end
    // Read byte held for the system side until the next one
    if (l_d.rx_v) begin
      l_d.rd_hold = l_d.rx;
      l_d.rd_tgl = !l_q.rd_tgl;
    end
  end

  // Data input passes three stages
  always_ff @(posedge link_clk) begin
    miso_s1_q <= {7'h00, spi_miso};
    miso_s2_q <= miso_s1_q;
    miso_s3_q <= miso_s2_q;
  end

  // Reset crosses into the link domain through three stages
  always_ff @(posedge link_clk) begin
    lrst_q <= {lrst_q[1:0], rst};
  end

  always_ff @(posedge link_clk) begin
    if (lrst_q[2]) begin
      l_q <= '0;
      l_q.cs_n <= 1'b1;
    end else begin
      l_q <= l_d;
    end
  end

  assign boot_chip_select = l_q.cs_n;
  assign spi_sck = l_q.sck;
  assign spi_mosi = l_q.mosi;
endmodule

// [sfbs_sequencer_assertions.sv]
`timescale 1ns/1ps
module sfbs_sequencer_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic boot_done,
  input wire logic seq_busy,
  input wire logic boot_chip_select,
  input wire logic chip_select_1,
  input wire logic spi_sck,
  input wire logic spi_mosi
);
  ////////////////////////////////////////////////////////////////
  // Link-side run lengths; select-high count saturates so a long idle never wraps
  logic [7:0] cs_hi_q;
  logic [7:0] sck_hi_q;
  always_ff @(posedge link_clk) begin
    if (rst || (boot_chip_select && cs_hi_q != 8'hFF)) cs_hi_q <= rst ? 8'hFF : cs_hi_q + 8'h01;
    else if (!boot_chip_select) cs_hi_q <= 8'h00;
    sck_hi_q <= (rst || !spi_sck) ? 8'h00 : sck_hi_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_sck_fall;
    $fell(spi_sck);
  endsequence
  property p_idle_sck_low;
    @(posedge link_clk) disable iff (rst) boot_chip_select |-> !spi_sck;
  endproperty
  property p_cs_gap;
    @(posedge link_clk) disable iff (rst) $fell(boot_chip_select) |-> cs_hi_q >= sfbs_pkg::CS_HIGH_CYC;
  endproperty
  property p_mosi_hold;
    @(posedge link_clk) disable iff (rst)
      !boot_chip_select && spi_sck && $past(spi_sck) |-> $stable(spi_mosi);
  endproperty
  property p_slow_boot;
    @(posedge link_clk) disable iff (rst) s_sck_fall ##0 !boot_done |->
      sck_hi_q inside {[sfbs_pkg::SLOW_HALF - 8'h01 : sfbs_pkg::SLOW_HALF + 8'h01]};
  endproperty
  property p_fast_after;
    @(posedge link_clk) disable iff (rst)
      s_sck_fall ##0 boot_done |-> sck_hi_q <= sfbs_pkg::FAST_HALF + 8'h01;
  endproperty
  property p_cs1_idle;
    @(posedge clk) disable iff (rst) 1'b1 |-> chip_select_1 ##1 chip_select_1;
  endproperty
  property p_take_busy;
    @(posedge clk) disable iff (rst) s_take |=> seq_busy;
  endproperty
  property p_no_req_in_boot;
    @(posedge clk) disable iff (rst) !boot_done |-> !req_ready;
  endproperty
  property p_boot_sticky;
    @(posedge clk) disable iff (rst) boot_done |=> boot_done [*2];
  endproperty
  a_idle_sck_low: assert property (p_idle_sck_low) else $error("clock high while idle");
  a_cs_gap: assert property (p_cs_gap) else $error("select gap short");
  a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
  a_slow_boot: assert property (p_slow_boot) else $error("boot clock not slow");
  a_fast_after: assert property (p_fast_after) else $error("clock not fast after boot");
  a_cs1_idle: assert property (p_cs1_idle) else $error("second select used");
  a_take_busy: assert property (p_take_busy) else $error("busy missing after take");
  a_no_req_in_boot: assert property (p_no_req_in_boot) else $error("ready before boot");
  a_boot_sticky: assert property (p_boot_sticky) else $error("boot done dropped");
endmodule
bind sfbs_sequencer sfbs_sequencer_assertions u_chk (.clk(clk), .rst(rst), .link_clk(link_clk),
  .req_valid(req_valid), .req_ready(req_ready), .boot_done(boot_done), .seq_busy(seq_busy),
  .boot_chip_select(boot_chip_select), .chip_select_1(chip_select_1), .spi_sck(spi_sck),
  .spi_mosi(spi_mosi));

// [sfbs_sequencer_tb.sv]
`timescale 1ns/1ps
module sfbs_sequencer_tb;
  logic clk, rst, link_clk, req_valid, req_ready, wr_valid, wr_ready, rd_valid;
  logic boot_done, seq_busy, cs0_n, cs1_n, spi_sck, spi_mosi, spi_miso;
  logic [2:0] req_kind;
  logic [23:0] req_addr;
  logic [8:0] req_len;
  logic [7:0] wr_data, rd_data, last_status, rd_q[$], ex_op[$];
  logic [7:0] ex_dat[22] = '{8'h00, 8'h00, 8'h01, 8'hFC, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'h00,
    8'h02, 8'h00, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'h01, 8'h23, 8'h45, 8'h00, 8'h01, 8'h00, 8'h00};
  int bad_count, n_checks, n, i, ex_bits[$];
  sfbs_sequencer u_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .req_kind(req_kind),
    .req_addr(req_addr), .req_len(req_len), .req_valid(req_valid), .req_ready(req_ready),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .boot_done(boot_done), .seq_busy(seq_busy),
    .last_status(last_status), .boot_chip_select(cs0_n), .chip_select_1(cs1_n),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  sfbs_flash_model u_flash (.sck(spi_sck), .cs_n(cs0_n), .mosi(spi_mosi), .miso(spi_miso));
  initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
  initial begin link_clk = 1'b0; #1.7; forever #3 link_clk = ~link_clk; end
  // Read bytes are one-cycle pulses
  always @(negedge clk) if (rd_valid === 1'b1) rd_q.push_back(rd_data);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Write enable, slow latch polls, command, then busy polls
  task automatic ex_wr(input logic [7:0] op, input int b);
    ex_op.push_back(8'h06); ex_bits.push_back(8);
    repeat (3) begin ex_op.push_back(8'h05); ex_bits.push_back(16); end
    ex_op.push_back(op); ex_bits.push_back(b);
    repeat (3) begin ex_op.push_back(8'h05); ex_bits.push_back(16); end
  endtask
  // Request held until taken, then wait for idle
  task automatic req(input logic [2:0] k, input logic [23:0] a, input logic [8:0] l);
    req_kind = k; req_addr = a; req_len = l; req_valid = 1'b1; n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin @(posedge clk); #1; n++; end
    @(posedge clk); #1;
    req_valid = 1'b0; n = 0;
    while (seq_busy !== 1'b0 && n < 20000) begin @(posedge clk); #1; n++; end
    chk("idle", 1, n < 20000);
  endtask
  initial begin
    #1000000;
    bad_count++;
    $display("BAD watchdog expected finish seen timeout");
    test_done();
  end
  initial begin
    rst = 1'b1; req_valid = 1'b0; req_kind = 3'h0; req_addr = 24'h000000; req_len = 9'h000;
    wr_valid = 1'b0; wr_data = 8'h00; bad_count = 0; n_checks = 0; n = 0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    while (boot_done !== 1'b1 && n < 10000) begin @(posedge clk); #1; n++; end
    chk("boot_done", 1, boot_done);
    chk("flash_status", 8'h00, u_flash.st);
    wr_valid = 1'b1;
    for (i = 0; i < 8; i++) begin
      wr_data = 8'hC0 + 8'(i); n = 0;
      while (wr_ready !== 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
      @(posedge clk); #1;
    end
    wr_valid = 1'b0;
    @(posedge clk); #1;
    chk("fifo_full", 0, wr_ready);
    req(3'h1, 24'h0001FC, 9'h008);
    req(3'h1, 24'h000200, 9'h004);
    req(3'h2, 24'h012345, 9'h000);
    req(3'h3, 24'h000000, 9'h000);
    req(3'h4, 24'h000100, 9'h003);
    repeat (6) @(posedge clk);
    #1;
    chk("fifo_empty", 1, wr_ready);
    chk("last_status", 8'h00, last_status);
    ex_op = '{8'h06, 8'h05, 8'h05, 8'h05, 8'h01};
    ex_bits = '{8, 16, 16, 16, 16};
    ex_wr(8'h02, 64);
    ex_wr(8'h02, 64);
    ex_wr(8'h20, 32);
    ex_wr(8'hC7, 8);
    ex_op.push_back(8'h0B); ex_bits.push_back(64);
    chk("frames", ex_op.size(), u_flash.ops.size());
    for (i = 0; i < ex_op.size() && i < u_flash.ops.size(); i++) begin
      chk("opcode", ex_op[i], u_flash.ops[i]);
      chk("frame_bits", ex_bits[i], u_flash.bits[i]);
    end
    chk("bytes", 22, u_flash.dat.size());
    for (i = 0; i < 22 && i < u_flash.dat.size(); i++) chk("byte", ex_dat[i], u_flash.dat[i]);
    chk("reads", 3, rd_q.size());
    for (i = 0; i < rd_q.size(); i++) chk("rd_data", 8'hA0 + 8'(i), rd_q[i]);
    test_done();
  end
endmodule
